// [hold_timer.sv]
`timescale 1ns/1ps
`include "rsc_defs.svh"

// holds busy while req is high, then for len more cycles
module hold_timer (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    ce,
  input  wire logic                    req,
  input  wire logic [`TIMER_W-1:0]     len,
  output logic                         busy
);

  logic [`TIMER_W-1:0] cnt;  // cycles still to hold

  // ------------
  // reload while asked, then count down
  // ------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= '0;
    end else if (ce) begin
      if (req) begin
        cnt <= len;                    // restart on every request cycle
      end else if (cnt != '0) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  assign busy = req | (cnt != '0);

endmodule : hold_timer

// [reset_source_controller.sv]
`timescale 1ns/1ps
`include "rsc_defs.svh"

// Notes on behaviour
// [RULE1] below a level: interrupt or reset, as configured
// [RULE2] voltage reset held for stabilization after recovery
// [RULE3] voltage detection disabled after every reset
// [RULE4] standby wake gives reset and oscillator restart
// [RULE5] standby reset held for six-bit wait time
// [RULE6] independent watchdog underflow: reset, set flag
// [RULE7] independent watchdog reset self-releases after delay
// [RULE8] system watchdog resets only when reset enabled
// [RULE9] watchdog overflow: pin low, flag set
// [RULE10] system watchdog reset self-releases after delay
// [RULE11] power-on flag set by power-on, cleared pin
// [RULE12] independent watchdog refresh error also resets
// [RULE13] pin low holds the device in reset
// [RULE14] cause flags survive the reset they record
module reset_source_controller (
  input  wire logic        CLK,
  input  wire logic        RESET,           // power-on detector
  input  wire logic        CE,
  input  wire logic        EXT_RESET_N,
  input  wire logic        LOW_VOLT_LEVEL_ONE,
  input  wire logic        LOW_VOLT_LEVEL_TWO,
  input  wire logic        STANDBY_WAKE,
  input  wire logic        IWDG_UNDERFLOW,
  input  wire logic        IWDG_REFRESH_ERR,
  input  wire logic        WDG_OVERFLOW,
  output logic             SYS_RESET,
  output logic             OSC_START,
  output logic             WATCHDOG_OVERFLOW_OUT_N,
  output logic             IRQ,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);
  // ------------
  // cycle counts derived from times
  // ------------
  localparam int POR_CYC   = (`POR_HOLD_NS + `CLK_NS - 1) / `CLK_NS;
  localparam int STAB_CYC  = (`LV_STAB_NS + `CLK_NS - 1) / `CLK_NS;
  localparam int WDG_CYC   = (`WDG_DELAY_NS + `CLK_NS - 1) / `CLK_NS;
  localparam int DSTEP_CYC = (`DSTBY_STEP_NS + `CLK_NS - 1) / `CLK_NS;
  // ------------
  // declarations
  // ------------
  rsc_pkg::ctrl_t      ctrl;               // control word
  rsc_pkg::bus_state_t bus_state;          // bus sequencer
  logic [`FLAG_W-1:0]  flags;              // reset_status_reg
  logic [`INT_W-1:0]   int_status;         // sticky events
  logic [`INT_W-1:0]   int_enable;         // interrupt mask
  logic [`SRC_N-1:0]   src_req;            // timer requests
  logic [`SRC_N-1:0]   src_busy;           // timer outputs
  logic [`TIMER_W-1:0] hold_len [`SRC_N];  // per-source hold
  logic                por_req;            // one cycle after power-on
  logic [1:0]          lv_below, lv_prev;  // levels, now and last cycle
  logic [1:0]          lv_en, lv_rst;      // enable, reset choice
  logic [1:0]          lv_trip;            // voltage reset active
  logic                wdg_arm;            // overflow became a reset
  logic                next_sys_reset;
  logic [`INT_W-1:0]   int_event;
  logic [7:0]          aw_addr, ar_addr;   // captured addresses
  logic [31:0]         w_data, rd_word;
  logic [3:0]          w_strb;
  logic                aw_have, w_have, ar_have;
  logic                wr_go, rd_go;       // access performed now
  rsc_pkg::reg_sel_t   wr_sel, rd_sel;
  // ------------
  // address decode, shared by both paths
  // ------------
  function automatic rsc_pkg::reg_sel_t decode(input logic [7:0] addr);
    logic [7:0] word_addr;
    word_addr = {addr[7:2], 2'b00};
    case (word_addr)
      `OFS_RESET_STATUS: decode = rsc_pkg::SEL_RST;
      `OFS_INT_STATUS:   decode = rsc_pkg::SEL_IST;
      `OFS_INT_CLEAR:    decode = rsc_pkg::SEL_ICLR;
      `OFS_INT_ENABLE:   decode = rsc_pkg::SEL_IEN;
      `OFS_CTRL:         decode = rsc_pkg::SEL_CTRL;
      default:           decode = rsc_pkg::SEL_NONE;
    endcase
  endfunction : decode

  assign wr_sel   = decode(aw_addr);
  assign rd_sel   = decode(ar_addr);
  assign wr_go    = (bus_state == rsc_pkg::BUS_IDLE) & aw_have & w_have;
  assign rd_go    = (bus_state == rsc_pkg::BUS_IDLE) & ar_have & ~wr_go;
  assign lv_below = {LOW_VOLT_LEVEL_TWO, LOW_VOLT_LEVEL_ONE};
  assign lv_en    = {ctrl.lv_two_en, ctrl.lv_one_en};
  assign lv_rst   = {ctrl.lv_two_rst, ctrl.lv_one_rst};
  // ------------
  // reset sources and hold lengths
  // ------------
  assign src_req[`SRC_POR]    = por_req;
  assign src_req[`SRC_LV_ONE] = lv_trip[0];                         // RULE2
  assign src_req[`SRC_LV_TWO] = lv_trip[1];                         // RULE2
  assign src_req[`SRC_DSTBY]  = STANDBY_WAKE;                       // RULE4
  assign src_req[`SRC_IWDG]   = IWDG_UNDERFLOW | IWDG_REFRESH_ERR;  // RULE6 RULE12
  assign src_req[`SRC_WDG]    = WDG_OVERFLOW;

  assign hold_len[`SRC_POR]    = `TIMER_W'(POR_CYC);
  assign hold_len[`SRC_LV_ONE] = `TIMER_W'(STAB_CYC);
  assign hold_len[`SRC_LV_TWO] = `TIMER_W'(STAB_CYC);
  assign hold_len[`SRC_DSTBY]  = `TIMER_W'((32'(ctrl.wait_time) + 1) * DSTEP_CYC); // RULE5
  assign hold_len[`SRC_IWDG]   = `TIMER_W'(WDG_CYC);                // RULE7
  assign hold_len[`SRC_WDG]    = `TIMER_W'(WDG_CYC);                // RULE10

  // one hold timer per source
  genvar gi;
  generate
    for (gi = 0; gi < `SRC_N; gi++) begin : g_hold
      hold_timer u_hold (
        .clk   (CLK),
        .reset (RESET),
        .ce    (CE),
        .req   (src_req[gi]),
        .len   (hold_len[gi]),
        .busy  (src_busy[gi])
      );
    end
  endgenerate
  // ------------
  // reset combine; pin acts at once, others timed
  // ------------
  assign next_sys_reset = ~EXT_RESET_N                  // RULE13
                        | src_busy[`SRC_POR]
                        | src_busy[`SRC_LV_ONE]
                        | src_busy[`SRC_LV_TWO]
                        | src_busy[`SRC_DSTBY]           // RULE5
                        | src_busy[`SRC_IWDG]            // RULE7
                        | (src_busy[`SRC_WDG] & wdg_arm); // RULE8

  // registered reset and oscillator outputs
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      SYS_RESET               <= 1'b1;
      OSC_START               <= 1'b0;
      WATCHDOG_OVERFLOW_OUT_N <= 1'b1;
      por_req                 <= 1'b1;
    end else if (CE) begin
      SYS_RESET               <= next_sys_reset;
      OSC_START               <= src_busy[`SRC_DSTBY];       // RULE4
      WATCHDOG_OVERFLOW_OUT_N <= ~src_busy[`SRC_WDG];        // RULE9
      por_req                 <= 1'b0;
    end
  end

  // watchdog reset choice is caught at the overflow itself
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      wdg_arm <= 1'b0;
    end else if (CE) begin
      if (WDG_OVERFLOW) begin
        wdg_arm <= ctrl.wdg_rst_en;                          // RULE8
      end else if (!src_busy[`SRC_WDG]) begin
        wdg_arm <= 1'b0;
      end
    end
  end
  // ------------
  // voltage monitors; trip lasts until supply recovers
  // ------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      lv_prev <= 2'h0;
      lv_trip <= 2'h0;
    end else if (CE) begin
      lv_prev <= lv_below;
      for (int i = 0; i < 2; i++) begin
        if (!lv_below[i]) begin
          lv_trip[i] <= 1'b0;                                // RULE2
        end else if (!lv_prev[i] && lv_en[i] && lv_rst[i]) begin
          lv_trip[i] <= 1'b1;                                // RULE1
        end
      end
    end
  end

  // interrupt events; watchdog only when it did not reset
  assign int_event[`INT_LV_ONE] = lv_below[0] & ~lv_prev[0] & lv_en[0] & ~lv_rst[0]; // RULE1
  assign int_event[`INT_LV_TWO] = lv_below[1] & ~lv_prev[1] & lv_en[1] & ~lv_rst[1]; // RULE1
  assign int_event[`INT_WDG]    = WDG_OVERFLOW & ~ctrl.wdg_rst_en;                   // RULE8
  // ------------
  // control word; voltage enables cleared under every reset, whole word only at power-on
  // ------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ctrl <= '0;
    end else if (CE) begin
      if (SYS_RESET) begin
        ctrl.lv_one_en <= 1'b0;                              // RULE3
        ctrl.lv_two_en <= 1'b0;                              // RULE3
      end else if (wr_go && wr_sel == rsc_pkg::SEL_CTRL) begin
        if (w_strb[0]) begin
          ctrl.wdg_rst_en <= w_data[4];
          ctrl.lv_two_rst <= w_data[3];
          ctrl.lv_two_en  <= w_data[2];
          ctrl.lv_one_rst <= w_data[1];
          ctrl.lv_one_en  <= w_data[0];
        end
        if (w_strb[1]) begin
          ctrl.wait_time <= w_data[13:8];
        end
      end
    end
  end
  // ------------
  // cause flags; power-on and bus writes clear them, SYS_RESET does not
  // ------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      flags <= `FLAG_RESET_VAL;                              // RULE11
    end else if (CE) begin
      // write one to clear first, so a same-cycle set wins
      if (wr_go && wr_sel == rsc_pkg::SEL_RST && w_strb[0]) begin
        flags <= flags & ~w_data[`FLAG_W-1:0];
      end
      if (!EXT_RESET_N) begin
        flags[`FLAG_POWER_ON] <= 1'b0;                       // RULE11
      end
      if (WDG_OVERFLOW) begin
        flags[`FLAG_WDG_OVF] <= 1'b1;                        // RULE9 RULE14
      end
      if (src_req[`SRC_IWDG]) begin
        flags[`FLAG_IWDG_UNDER] <= 1'b1;                     // RULE6 RULE14
      end
      if (STANDBY_WAKE) begin
        flags[`FLAG_DSTBY] <= 1'b1;                          // RULE14
      end
      if (lv_trip[0]) begin
        flags[`FLAG_LV_ONE] <= 1'b1;                         // RULE14
      end
      if (lv_trip[1]) begin
        flags[`FLAG_LV_TWO] <= 1'b1;                         // RULE14
      end
    end
  end
  // ------------
  // interrupt status, enable and output
  // ------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      int_status <= '0;
      int_enable <= '0;
      IRQ        <= 1'b0;
    end else if (CE) begin
      // set wins over a clear in the same cycle
      if (wr_go && wr_sel == rsc_pkg::SEL_ICLR && w_strb[0]) begin
        int_status <= (int_status & ~w_data[`INT_W-1:0]) | int_event;
      end else begin
        int_status <= int_status | int_event;
      end
      if (wr_go && wr_sel == rsc_pkg::SEL_IEN && w_strb[0]) begin
        int_enable <= w_data[`INT_W-1:0];
      end
      IRQ <= |(int_status & int_enable);
    end
  end
  // ------------
  // bus: capture address and data in either order
  // ------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_ARREADY <= 1'b0;
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      ar_have       <= 1'b0;
      aw_addr       <= 8'h00;
      ar_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else if (CE) begin
      // ready is a one-cycle pulse, so each item is taken once
      S_AXI_AWREADY <= ~aw_have & S_AXI_AWVALID & ~S_AXI_AWREADY;
      S_AXI_WREADY  <= ~w_have & S_AXI_WVALID & ~S_AXI_WREADY;
      S_AXI_ARREADY <= ~ar_have & S_AXI_ARVALID & ~S_AXI_ARREADY;
      if (S_AXI_AWREADY && S_AXI_AWVALID) begin
        aw_have <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end else if (wr_go) begin
        aw_have <= 1'b0;
      end
      if (S_AXI_WREADY && S_AXI_WVALID) begin
        w_have <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end else if (wr_go) begin
        w_have <= 1'b0;
      end
      if (S_AXI_ARREADY && S_AXI_ARVALID) begin
        ar_have <= 1'b1;
        ar_addr <= S_AXI_ARADDR;
      end else if (rd_go) begin
        ar_have <= 1'b0;
      end
    end
  end

  // read data mux; write-only and unmapped read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (rd_sel)
      rsc_pkg::SEL_RST:  rd_word[`FLAG_W-1:0] = flags;
      rsc_pkg::SEL_IST:  rd_word[`INT_W-1:0]  = int_status;
      rsc_pkg::SEL_IEN:  rd_word[`INT_W-1:0]  = int_enable;
      rsc_pkg::SEL_CTRL: rd_word = {18'h00000, ctrl.wait_time, 3'h0,
                                    ctrl.wdg_rst_en, ctrl.lv_two_rst, ctrl.lv_two_en,
                                    ctrl.lv_one_rst, ctrl.lv_one_en};
      default:           rd_word = 32'h0000_0000;
    endcase
  end
  // ------------
  // bus sequencer; writes take priority over reads
  // ------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      bus_state    <= rsc_pkg::BUS_IDLE;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `RESP_OKAY;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RRESP  <= `RESP_OKAY;
      S_AXI_RDATA  <= 32'h0000_0000;
    end else if (CE) begin
      case (bus_state)
        rsc_pkg::BUS_IDLE: begin
          if (wr_go) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= (wr_sel == rsc_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            bus_state    <= rsc_pkg::BUS_WRESP;
          end else if (rd_go) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= rd_word;
            S_AXI_RRESP  <= (rd_sel == rsc_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            bus_state    <= rsc_pkg::BUS_RRESP;
          end
        end
        rsc_pkg::BUS_WRESP: begin
          if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            bus_state    <= rsc_pkg::BUS_IDLE;
          end
        end
        rsc_pkg::BUS_RRESP: begin
          if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            bus_state    <= rsc_pkg::BUS_IDLE;
          end
        end
        default: bus_state <= rsc_pkg::BUS_IDLE;  // recover from illegal code
      endcase
    end
  end

endmodule : reset_source_controller

// [reset_source_controller_tb_top.sv]
`timescale 1ns/1ps
module reset_source_controller_tb_top;
  typedef struct {
    logic [2:0]  sel;
    logic [15:0] ctrl;
    logic [7:0]  st;
    logic [7:0]  ist;
    int          lo;
    int          hi;
  } row_t; // event, control word, flags, interrupt flags, reset length

  logic        clk, reset, ev_go, ext_reset_n, lv_one, lv_two, wake;
  logic        iwdg_under, iwdg_err, wdg_ovf, sys_reset, osc_start, wdg_out_n, irq;
  logic [2:0]  ev_sel;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, q;
  logic [1:0]  bresp, rresp, r;
  int          len, err_count, checks_done;
  row_t        rows [12] = '{
    '{3'h4, 16'h0000, 8'h02, 8'h00, 20, 26},
    '{3'h5, 16'h0000, 8'h02, 8'h00, 20, 26},
    '{3'h3, 16'h0000, 8'h04, 8'h00, 20, 26},
    '{3'h3, 16'h0200, 8'h04, 8'h00, 60, 66},
    '{3'h3, 16'h3F00, 8'h04, 8'h00, 1280, 1286},
    '{3'h6, 16'h0010, 8'h01, 8'h00, 20, 26},
    '{3'h6, 16'h0000, 8'h01, 8'h04, 0, 0},
    '{3'h1, 16'h0003, 8'h10, 8'h00, 2000, 2012},
    '{3'h2, 16'h000C, 8'h08, 8'h00, 2000, 2012},
    '{3'h1, 16'h0001, 8'h00, 8'h01, 0, 0},
    '{3'h2, 16'h0004, 8'h00, 8'h02, 0, 0},
    '{3'h1, 16'h0000, 8'h00, 8'h00, 0, 0}};

  reset_source_controller u_reset_source_controller (
    .CLK(clk), .RESET(reset), .CE(1'b1), .EXT_RESET_N(ext_reset_n),
    .LOW_VOLT_LEVEL_ONE(lv_one), .LOW_VOLT_LEVEL_TWO(lv_two), .STANDBY_WAKE(wake),
    .IWDG_UNDERFLOW(iwdg_under), .IWDG_REFRESH_ERR(iwdg_err), .WDG_OVERFLOW(wdg_ovf),
    .SYS_RESET(sys_reset), .OSC_START(osc_start), .WATCHDOG_OVERFLOW_OUT_N(wdg_out_n),
    .IRQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  rsc_far_side u_rsc_far_side (
    .clk(clk), .reset(reset), .go(ev_go), .sel(ev_sel), .ext_reset_n(ext_reset_n),
    .lv_one(lv_one), .lv_two(lv_two), .wake(wake), .iwdg_under(iwdg_under),
    .iwdg_err(iwdg_err), .wdg_ovf(wdg_ovf));

  // ------------
  // verdict and comparisons
  // ------------
  task automatic wrap_up();
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // reset length must fall inside lo..hi cycles
  task automatic chk_len(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_len

  // ------------
  // one AXI4-Lite transfer, answer accepted late
  // ------------
  task automatic bus(input bit we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic [1:0] rs);
    int n;
    rd = 32'h0;
    rs = 2'h3;
    if (we) begin
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wvalid  <= 1'b1;
    end else begin
      araddr  <= a;
      arvalid <= 1'b1;
    end
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      // ready only after seeing the answer, so the answer must stand
      if (we ? bvalid : rvalid) begin
        if (we ? bready : rready) begin
          rd = rdata;
          rs = we ? bresp : rresp;
          bready <= 1'b0;
          rready <= 1'b0;
          break;
        end
        if (we) bready <= 1'b1;
        else rready <= 1'b1;
      end
    end
    if (n == 200) begin
      err_count++;
      wrap_up();
    end
  endtask : bus

  // fires one far-side event and measures the internal reset it causes
  task automatic fire(input logic [2:0] s, output int n_rst);
    int i;
    n_rst = 0;
    ev_sel <= s;
    ev_go  <= 1'b1;
    @(posedge clk);
    ev_go <= 1'b0;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk);
      if (sys_reset === 1'b1) n_rst++;
      else if (n_rst > 0 || i > 40) break;
    end
    if (i == 3000) begin
      err_count++;
      wrap_up();
    end
  endtask : fire

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    {ev_go, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {ev_sel, awaddr, araddr, wdata, err_count, checks_done} = '0;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    fire(3'h7, len);
    bus(1'b1, 8'h00, 32'h3F, q, r);
    bus(1'b1, 8'h0C, 32'h7, q, r);
    foreach (rows[k]) begin
      bus(1'b1, 8'h10, {16'h0, rows[k].ctrl}, q, r);
      fire(rows[k].sel, len);
      chk_len(len, rows[k].lo, rows[k].hi);
      bus(1'b0, 8'h00, 32'h0, q, r);
      chk(q, {24'h0, rows[k].st});
      bus(1'b0, 8'h04, 32'h0, q, r);
      chk(q, {24'h0, rows[k].ist});
      chk({31'h0, irq}, {31'h0, rows[k].ist != 8'h00});
      bus(1'b1, 8'h00, 32'h3F, q, r);
      bus(1'b1, 8'h08, 32'h7, q, r);
    end
    // masked overflow interrupt, then unmasked and cleared
    bus(1'b1, 8'h0C, 32'h0, q, r);
    bus(1'b1, 8'h10, 32'h0, q, r);
    fire(3'h6, len);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 8'h04, 32'h0, q, r);
    bus(1'b0, 8'h04, 32'h0, q, r);
    chk(q, 32'h4);
    bus(1'b1, 8'h0C, 32'h4, q, r);
    bus(1'b0, 8'h0C, 32'h0, q, r);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, 8'h08, 32'h4, q, r);
    bus(1'b0, 8'h04, 32'h0, q, r);
    chk({q[30:0], irq}, 32'h0);
    // unmapped place refuses both ways
    bus(1'b0, 8'h14, 32'h0, q, r);
    chk({q[29:0], r}, 32'h2);
    bus(1'b1, 8'h14, 32'hFFFFFFFF, q, r);
    chk({30'h0, r}, 32'h2);
    // second power-on in mid-run, then a pin reset
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    fire(3'h7, len);
    bus(1'b0, 8'h00, 32'h0, q, r);
    chk(q, 32'h20);
    bus(1'b0, 8'h10, 32'h0, q, r);
    chk(q, 32'h0);
    fire(3'h0, len);
    chk_len(len, 3, 8);
    bus(1'b0, 8'h00, 32'h0, q, r);
    chk(q, 32'h0);
    wrap_up();
  end
endmodule : reset_source_controller_tb_top

bind reset_source_controller rsc_sva u_rsc_sva (.*);

// [rsc_defs.svh]
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// ------------
// register byte offsets
// ------------
`define OFS_RESET_STATUS   8'h00
`define OFS_INT_STATUS     8'h04
`define OFS_INT_CLEAR      8'h08
`define OFS_INT_ENABLE     8'h0C
`define OFS_CTRL           8'h10

// ------------
// reset cause flags in reset_status_reg
// ------------
`define FLAG_WDG_OVF       0
`define FLAG_IWDG_UNDER    1
`define FLAG_DSTBY         2
`define FLAG_LV_TWO        3
`define FLAG_LV_ONE        4
`define FLAG_POWER_ON      5
`define FLAG_W             6
`define FLAG_RESET_VAL     6'h20

// ------------
// interrupt status / clear / enable bits
// ------------
`define INT_LV_ONE         0
`define INT_LV_TWO         1
`define INT_WDG            2
`define INT_W              3

// ------------
// reset sources, one hold timer each
// ------------
`define SRC_POR            0
`define SRC_LV_ONE         1
`define SRC_LV_TWO         2
`define SRC_DSTBY          3
`define SRC_IWDG           4
`define SRC_WDG            5
`define SRC_N              6

// ------------
// timing, in ns, and the clock period
// ------------
`define CLK_NS             50
`define POR_HOLD_NS        10000
`define LV_STAB_NS         100000
`define WDG_DELAY_NS       1000
`define DSTBY_STEP_NS      1000

// ------------
// bus answers and hold timer width
// ------------
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`define TIMER_W            16

`endif

// [rsc_far_side.sv]
`timescale 1ns/1ps
// --------------------------------------------
// pin, comparators and watchdogs on command
// --------------------------------------------
module rsc_far_side (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       go,
  input  wire logic [2:0] sel,
  output logic            ext_reset_n,
  output logic            lv_one,
  output logic            lv_two,
  output logic            wake,
  output logic            iwdg_under,
  output logic            iwdg_err,
  output logic            wdg_ovf
);
  logic [2:0] left; // cycles the event still stands
  logic [2:0] cur;  // event shown, 7 is none

  // one event at a time, started by go
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      left <= 3'h0;
      cur  <= 3'h7;
    end else if (go) begin
      left <= 3'h4;
      cur  <= sel;
    end else if (left != 3'h0) begin
      left <= left - 3'h1;
    end
  end

  // pin and supply dips stand four cycles, watchdog events pulse once
  assign ext_reset_n = !(left != 3'h0 && cur == 3'h0);
  assign lv_one      = left != 3'h0 && cur == 3'h1;
  assign lv_two      = left != 3'h0 && cur == 3'h2;
  assign wake        = left == 3'h4 && cur == 3'h3;
  assign iwdg_under  = left == 3'h4 && cur == 3'h4;
  assign iwdg_err    = left == 3'h4 && cur == 3'h5;
  assign wdg_ovf     = left == 3'h4 && cur == 3'h6;
endmodule : rsc_far_side

// [rsc_pkg.sv]
package rsc_pkg;

  // software control word of the block
  typedef struct packed {
    logic [5:0] wait_time;    // deep_standby_wait_time
    logic       wdg_rst_en;   // watchdog_reset_enable
    logic       lv_two_rst;   // 1: reset, 0: interrupt
    logic       lv_two_en;
    logic       lv_one_rst;
    logic       lv_one_en;
  } ctrl_t;

  // bus sequencer, one-hot
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_WRESP = 3'b010,
    BUS_RRESP = 3'b100
  } bus_state_t;

  // register select
  typedef enum logic [2:0] {
    SEL_NONE, SEL_RST, SEL_IST, SEL_ICLR, SEL_IEN, SEL_CTRL
  } reg_sel_t;

endpackage : rsc_pkg

// [rsc_sva.sv]
`timescale 1ns/1ps
// --------------------------------------------
// port checker for the reset source controller
// --------------------------------------------
module rsc_sva (
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic        CE,
  input wire logic        EXT_RESET_N,
  input wire logic        LOW_VOLT_LEVEL_ONE,
  input wire logic        LOW_VOLT_LEVEL_TWO,
  input wire logic        STANDBY_WAKE,
  input wire logic        IWDG_UNDERFLOW,
  input wire logic        IWDG_REFRESH_ERR,
  input wire logic        WDG_OVERFLOW,
  input wire logic        SYS_RESET,
  input wire logic        OSC_START,
  input wire logic        WATCHDOG_OVERFLOW_OUT_N,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  logic [11:0] run_len; // reset cycles since the last source let go
  wire logic   asking = !EXT_RESET_N | LOW_VOLT_LEVEL_ONE | LOW_VOLT_LEVEL_TWO | STANDBY_WAKE
                        | IWDG_UNDERFLOW | IWDG_REFRESH_ERR | WDG_OVERFLOW;

  // counts only unrequested reset, so a held request never trips the bound
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      run_len <= 12'h000;
    end else if (!SYS_RESET || asking) begin
      run_len <= 12'h000;
    end else if (CE && run_len != 12'hFFF) begin
      run_len <= run_len + 12'h001;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  AST_PIN_HOLD: assert property (!EXT_RESET_N |-> ##[1:2] SYS_RESET)
    else $error("pin low without internal reset");
  AST_IWDG_UNDER: assert property (CE && IWDG_UNDERFLOW |-> ##[1:2] SYS_RESET)
    else $error("underflow without reset");
  AST_IWDG_REFRESH: assert property (CE && IWDG_REFRESH_ERR |-> ##[1:2] SYS_RESET)
    else $error("refresh error without reset");
  AST_WAKE_OSC: assert property (CE && STANDBY_WAKE |-> ##[1:3] (OSC_START && SYS_RESET))
    else $error("wake without reset and oscillator start");
  AST_WAKE_HOLD: assert property ($rose(OSC_START) |=> SYS_RESET [*8])
    else $error("standby reset released too early");
  AST_WDG_PIN: assert property (CE && WDG_OVERFLOW |-> ##[1:2] !WATCHDOG_OVERFLOW_OUT_N)
    else $error("overflow pin not driven low");
  AST_WDG_PIN_LEN: assert property ($fell(WATCHDOG_OVERFLOW_OUT_N) |=> !WATCHDOG_OVERFLOW_OUT_N [*8])
    else $error("overflow pin pulse too short");
  AST_RELEASE: assert property (run_len < 12'h7E4)
    else $error("internal reset never released");
  AST_B_STAND: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer withdrawn");
  AST_R_STAND: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer withdrawn");

  C_WDG: cover property ($fell(WATCHDOG_OVERFLOW_OUT_N));
  C_WAKE: cover property ($rose(OSC_START));
  C_REL: cover property ($fell(SYS_RESET));
endmodule : rsc_sva
